// ==== rtl/cpmc_pkg.sv ====
// Purpose: shared constants and types for the programmable macrocell
// Assumes: one core clock, synchronous active-low reset, word-wide register port
// Notes: Operation list follows
// Operation
// - register data comes from the xor gate or a dedicated product term
// - storage element works as d, t, jk or sr flip-flop
// - latch mode passes data while clock high, holds while clock low
// - clock is the global clock pin or a product term; rising edge updates
// - with global clock, a product term enable low makes edges ignored
// - async reset is clear pin, product term, their or, or off
// - async preset is a product term or off
// - output registered or combinatorial; registered output also feeds back
// - combinatorial output feeds back itself or register when dedicated term feeds it
// - output buffer can be always on or always off; pin then an input
// - output enable can also be either enable pin or a product term
// - product terms see the 68-bit global bus, true and complement
// - each macrocell drives an inverted product term onto a 16-wide regional bus
// - regional foldback terms allow sums of up to 21 product terms
// - five product terms, each fed by global and regional buses
package cpmc_pkg;
    localparam int GSIG = 34;
    localparam int BUS_W = 68;
    localparam int RBUS_W = 16;
    localparam int N_PT = 5;
    localparam int MASK_W = 84;
    localparam int MASK_WORDS = 3;
    localparam int N_MASK = 15;
    localparam int ADDR_W = 8;
    localparam logic [7:0] CFG_OFF = 8'h00;
    localparam logic [7:0] ALLOC_OFF = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h08;
    localparam logic [7:0] MASK_OFF = 8'h10;
    localparam logic [7:0] MASK_END = 8'h48;
    localparam int CFG_DSEL = 0;
    localparam int CFG_MODE = 1;
    localparam int CFG_CLKSEL = 4;
    localparam int CFG_CE_EN = 5;
    localparam int CFG_AR = 6;
    localparam int CFG_APSEL = 8;
    localparam int CFG_OSEL = 9;
    localparam int CFG_FBSEL = 10;
    localparam int CFG_OE = 11;
    localparam int CFG_XOR = 14;
    localparam int CFG_OR = 16;
    localparam int AL_DATA = 0;
    localparam int AL_AUX = 3;
    localparam int AL_CLK = 6;
    localparam int AL_CE = 9;
    localparam int AL_AR = 12;
    localparam int AL_AP = 15;
    localparam int AL_OE = 18;
    localparam int AL_XOR = 21;
    localparam int AL_FOLD = 24;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] ALLOC_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    typedef enum logic [2:0] {
        MODE_D = 3'h0, MODE_T = 3'h1, MODE_SR = 3'h3, MODE_JK = 3'h2, MODE_LATCH = 3'h6
    } cpmc_mode_t;
    typedef enum logic [1:0] {
        AR_OFF = 2'h0, AR_GLOBAL_CLEAR_PIN = 2'h1, AR_PT = 2'h3, AR_OR = 2'h2
    } cpmc_ar_t;
    typedef enum logic [2:0] {
        OE_ON = 3'h0, OE_OFF = 3'h1, OE_PIN_A = 3'h3, OE_PIN_B = 3'h2, OE_PT = 3'h6
    } cpmc_oe_t;
    typedef enum logic [1:0] {
        XOR_LOW = 2'h0, XOR_HIGH = 2'h1, XOR_PT = 2'h3
    } cpmc_xor_t;
endpackage

// ==== rtl/cpmc_pterm.sv ====
// Purpose: one product term of the macrocell array
// Assumes: mask bit high means the literal takes part in the and
// Notes: an empty mask gives a term that is always true
`timescale 1ns/1ps
`default_nettype none
module cpmc_pterm #(
    parameter int W = 84
) (
    input wire logic [W-1:0] lits,
    input wire logic [W-1:0] mask,
    output logic term
);
    assign term = &(lits | ~mask);
endmodule
`default_nettype wire

// ==== rtl/cpmc_store.sv ====
// Purpose: configurable storage element of the macrocell
// Assumes: the macrocell clock arrives as a level sampled on core_clk
// Notes: async reset and preset take effect at the next core_clk edge
`timescale 1ns/1ps
`default_nettype none
module cpmc_store (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire cpmc_pkg::cpmc_mode_t mode,
    input wire logic clk_lvl,
    input wire logic ce,
    input wire logic din_a,
    input wire logic din_b,
    input wire logic ar,
    input wire logic ap,
    output logic q
);
    logic clk_prev_reg;
    logic edge_seen;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            clk_prev_reg <= 1'b0;
        else
            clk_prev_reg <= clk_lvl;
    end

    assign edge_seen = clk_lvl && !clk_prev_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            q <= 1'b0;
        else if (ar)
            q <= 1'b0;
        else if (ap)
            q <= 1'b1;
        else if (mode == cpmc_pkg::MODE_LATCH)
        begin
            if (clk_lvl)
                q <= din_a;
        end
        else if (edge_seen && ce)
        begin
            case (mode)
                cpmc_pkg::MODE_D: q <= din_a;
                cpmc_pkg::MODE_T: q <= q ^ din_a;
                cpmc_pkg::MODE_JK: q <= (din_a && !q) || (!din_b && q);
                // s and r together clear, a safe reading of the forbidden case
                cpmc_pkg::MODE_SR: q <= (din_a && !din_b) || (q && !din_b);
                default: q <= q;
            endcase
        end
    end

    ar_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ar |=> !q) else $error("reset did not clear storage");
    ap_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ap && !ar |=> q) else $error("preset did not set storage");
    ce_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode != cpmc_pkg::MODE_LATCH && !ce && !ar && !ap |=> $stable(q))
        else $error("storage moved while enable low");
    latch_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == cpmc_pkg::MODE_LATCH && clk_lvl && !ar && !ap |=> q == $past(din_a))
        else $error("latch not transparent");
    latch_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == cpmc_pkg::MODE_LATCH && !clk_lvl && !ar && !ap |=> $stable(q))
        else $error("latch did not hold");
    d_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == cpmc_pkg::MODE_D && clk_lvl && !clk_prev_reg && ce && !ar && !ap
        |=> q == $past(din_a)) else $error("d flip-flop missed edge");
    t_toggle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == cpmc_pkg::MODE_T && edge_seen && ce && din_a && !ar && !ap
        |=> q != $past(q)) else $error("t flip-flop did not toggle");
endmodule
`default_nettype wire

// ==== rtl/cpmc_top.sv ====
// Purpose: one programmable logic macrocell with its product terms and output logic
// Assumes: all inputs synchronous to core_clk; config written over the register port
// Notes: every output is registered, so pin effects show one cycle after their cause
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module cpmc_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [cpmc_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [cpmc_pkg::GSIG-1:0] global_sig,
    input wire logic [cpmc_pkg::RBUS_W-1:0] regional_in,
    input wire logic cascade_input,
    input wire logic glob_clk,
    input wire logic global_clear_pin_n,
    input wire logic output_enable_pin_a_n,
    input wire logic output_enable_pin_b_n,
    output logic pin_out,
    output logic pin_oe,
    output logic buried_fb,
    output logic foldback_out
);
    logic [31:0] cfg_reg;
    logic [31:0] alloc_reg;
    logic [31:0] mask_reg [cpmc_pkg::N_MASK];
    logic [cpmc_pkg::BUS_W-1:0] gbus;
    logic [cpmc_pkg::MASK_W-1:0] pbus;
    logic [cpmc_pkg::N_PT-1:0] pt;
    logic dsel, clksel, ce_en, apsel, osel, fbsel;
    cpmc_pkg::cpmc_mode_t mode;
    cpmc_pkg::cpmc_ar_t arsel;
    cpmc_pkg::cpmc_oe_t oesel;
    cpmc_pkg::cpmc_xor_t xorsel;
    logic [cpmc_pkg::N_PT-1:0] or_mask;
    logic or_sum, xor_in, xor_out;
    logic din_a, din_b, clk_lvl, ce, ar, ap, q;
    logic fold_pt, out_next, fb_next;
    logic oe_next;

    // out-of-range allocator index picks a constant low term
    function automatic logic pick(input logic [cpmc_pkg::N_PT-1:0] terms,
                                  input logic [2:0] idx);
        logic r;
        r = 1'b0;
        if (idx < 3'(cpmc_pkg::N_PT))
            r = terms[idx];
        return r;
    endfunction

    function automatic logic mask_hit(input logic [cpmc_pkg::ADDR_W-1:0] a);
        return a >= cpmc_pkg::MASK_OFF && a <= cpmc_pkg::MASK_END && a[1:0] == 2'h0;
    endfunction

    function automatic logic [3:0] mask_idx(input logic [cpmc_pkg::ADDR_W-1:0] a);
        logic [cpmc_pkg::ADDR_W-1:0] off;
        off = a - cpmc_pkg::MASK_OFF;
        return off[5:2];
    endfunction

    // register writes; unmapped and read-only addresses ignore the strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cfg_reg <= cpmc_pkg::CFG_RST;
            alloc_reg <= cpmc_pkg::ALLOC_RST;
        end
        else if (wr)
        begin
            if (addr == cpmc_pkg::CFG_OFF)
                cfg_reg <= wdata;
            if (addr == cpmc_pkg::ALLOC_OFF)
                alloc_reg <= wdata;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < cpmc_pkg::N_MASK; i++)
                mask_reg[i] <= cpmc_pkg::MASK_RST;
        end
        else if (wr && mask_hit(addr))
        begin
            mask_reg[mask_idx(addr)] <= wdata;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdata <= 32'h0000_0000;
        else if (!rd)
            rdata <= 32'h0000_0000;
        else if (addr == cpmc_pkg::CFG_OFF)
            rdata <= cfg_reg;
        else if (addr == cpmc_pkg::ALLOC_OFF)
            rdata <= alloc_reg;
        else if (addr == cpmc_pkg::STAT_OFF)
            rdata <= {22'h000000, pt, foldback_out, buried_fb, pin_oe, pin_out, q};
        else if (mask_hit(addr))
            rdata <= mask_reg[mask_idx(addr)];
        else
            rdata <= 32'h0000_0000;
    end

    // configuration fields
    assign dsel = cfg_reg[cpmc_pkg::CFG_DSEL];
    assign mode = cpmc_pkg::cpmc_mode_t'(cfg_reg[cpmc_pkg::CFG_MODE +: 3]);
    assign clksel = cfg_reg[cpmc_pkg::CFG_CLKSEL];
    assign ce_en = cfg_reg[cpmc_pkg::CFG_CE_EN];
    assign arsel = cpmc_pkg::cpmc_ar_t'(cfg_reg[cpmc_pkg::CFG_AR +: 2]);
    assign apsel = cfg_reg[cpmc_pkg::CFG_APSEL];
    assign osel = cfg_reg[cpmc_pkg::CFG_OSEL];
    assign fbsel = cfg_reg[cpmc_pkg::CFG_FBSEL];
    assign oesel = cpmc_pkg::cpmc_oe_t'(cfg_reg[cpmc_pkg::CFG_OE +: 3]);
    assign xorsel = cpmc_pkg::cpmc_xor_t'(cfg_reg[cpmc_pkg::CFG_XOR +: 2]);
    assign or_mask = cfg_reg[cpmc_pkg::CFG_OR +: cpmc_pkg::N_PT];

    // every signal in true and complemented form
    assign gbus = {~global_sig, global_sig};
    // regional foldbacks widen the fan-in without extra array depth
    assign pbus = {regional_in, gbus};

    genvar k;
    generate
        for (k = 0; k < cpmc_pkg::N_PT; k++)
        begin : g_pt
            cpmc_pterm #(.W(cpmc_pkg::MASK_W)) u_pt (
                .lits(pbus),
                .mask({mask_reg[3*k+2][cpmc_pkg::MASK_W-65:0],
                       mask_reg[3*k+1], mask_reg[3*k]}),
                .term(pt[k])
            );
        end
    endgenerate

    // or gate, cascade chain and xor with its selectable second input
    assign or_sum = |(pt & or_mask) | cascade_input;

    always_comb
    begin
        case (xorsel)
            cpmc_pkg::XOR_LOW: xor_in = 1'b0;
            cpmc_pkg::XOR_HIGH: xor_in = 1'b1;
            cpmc_pkg::XOR_PT: xor_in = pick(pt, alloc_reg[cpmc_pkg::AL_XOR +: 3]);
            default: xor_in = 1'b0;
        endcase
    end

    assign xor_out = or_sum ^ xor_in;

    // storage element inputs
    assign din_a = dsel ? pick(pt, alloc_reg[cpmc_pkg::AL_DATA +: 3]) : xor_out;
    assign din_b = pick(pt, alloc_reg[cpmc_pkg::AL_AUX +: 3]);
    assign clk_lvl = clksel ? pick(pt, alloc_reg[cpmc_pkg::AL_CLK +: 3]) : glob_clk;
    // the enable only exists with the global clock pin as source
    assign ce = (!clksel && ce_en) ? pick(pt, alloc_reg[cpmc_pkg::AL_CE +: 3]) : 1'b1;

    always_comb
    begin
        case (arsel)
            cpmc_pkg::AR_OFF: ar = 1'b0;
            cpmc_pkg::AR_GLOBAL_CLEAR_PIN: ar = !global_clear_pin_n;
            cpmc_pkg::AR_PT: ar = pick(pt, alloc_reg[cpmc_pkg::AL_AR +: 3]);
            cpmc_pkg::AR_OR: ar = !global_clear_pin_n ||
                                  pick(pt, alloc_reg[cpmc_pkg::AL_AR +: 3]);
            default: ar = 1'b0;
        endcase
    end

    assign ap = apsel && pick(pt, alloc_reg[cpmc_pkg::AL_AP +: 3]);

    cpmc_store u_store (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mode(mode),
        .clk_lvl(clk_lvl),
        .ce(ce),
        .din_a(din_a),
        .din_b(din_b),
        .ar(ar),
        .ap(ap),
        .q(q)
    );

    // output and feedback selection
    assign out_next = osel ? xor_out : q;
    // register feedback from a combinatorial cell needs the dedicated data term
    assign fb_next = !osel ? q : ((fbsel && dsel) ? q : xor_out);

    always_comb
    begin
        case (oesel)
            cpmc_pkg::OE_ON: oe_next = 1'b1;
            cpmc_pkg::OE_OFF: oe_next = 1'b0;
            cpmc_pkg::OE_PIN_A: oe_next = !output_enable_pin_a_n;
            cpmc_pkg::OE_PIN_B: oe_next = !output_enable_pin_b_n;
            cpmc_pkg::OE_PT: oe_next = pick(pt, alloc_reg[cpmc_pkg::AL_OE +: 3]);
            default: oe_next = 1'b0;
        endcase
    end

    assign fold_pt = pick(pt, alloc_reg[cpmc_pkg::AL_FOLD +: 3]);

    // pins and buses stay driven with the buffer off, so the cell keeps working
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            buried_fb <= 1'b0;
            foldback_out <= 1'b0;
        end
        else
        begin
            pin_out <= out_next;
            pin_oe <= oe_next;
            buried_fb <= fb_next;
            foldback_out <= !fold_pt;
        end
    end

    out_reg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !osel |=> pin_out == $past(q) && buried_fb == $past(q))
        else $error("registered output and feedback differ");
    fb_comb_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        osel && !(fbsel && dsel) |=> buried_fb == $past(xor_out))
        else $error("combinatorial feedback wrong");
    fb_reg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        osel && fbsel && dsel |=> buried_fb == $past(q) && pin_out == $past(xor_out))
        else $error("buried register feedback wrong");
    oe_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        oesel == cpmc_pkg::OE_OFF |=> !pin_oe) else $error("disabled buffer drives");
    oe_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        oesel == cpmc_pkg::OE_PIN_A |=> pin_oe == !$past(output_enable_pin_a_n))
        else $error("enable pin a not followed");
    fold_inv_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> foldback_out == !$past(fold_pt))
        else $error("foldback not inverted term");
    global_clear_pin_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        arsel == cpmc_pkg::AR_GLOBAL_CLEAR_PIN && !global_clear_pin_n |=> !q)
        else $error("clear pin did not reset");
    data_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !dsel && mode == cpmc_pkg::MODE_LATCH && clk_lvl && !ar && !ap
        |=> q == $past(xor_out)) else $error("xor path not used as data");

    // register port: data only after a strobe, read-only and unmapped words inert
    rd_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rd
        |=> rdata == 32'h0000_0000) else $error("read data without strobe");
    rd_cfg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd && addr == cpmc_pkg::CFG_OFF
        |=> rdata == $past(cfg_reg)) else $error("config read wrong");
    rd_alloc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd && addr == cpmc_pkg::ALLOC_OFF
        |=> rdata == $past(alloc_reg)) else $error("allocator read wrong");
    rd_stat_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd && addr == cpmc_pkg::STAT_OFF
        |=> rdata[0] == $past(q)) else $error("status storage bit wrong");
    rd_unmapped_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd && addr > cpmc_pkg::MASK_END
        |=> rdata == 32'h0000_0000) else $error("unmapped read not zero");
    stat_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && addr == cpmc_pkg::STAT_OFF
        |=> $stable(cfg_reg) && $stable(alloc_reg)) else $error("status write landed");

    // control sources of the storage element
    ar_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        arsel == cpmc_pkg::AR_OFF
        |-> !ar) else $error("reset active while off");
    ar_or_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        arsel == cpmc_pkg::AR_OR && !global_clear_pin_n
        |-> ar) else $error("clear pin missing from or");
    ar_term_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        arsel == cpmc_pkg::AR_PT && pick(pt, alloc_reg[cpmc_pkg::AL_AR +: 3])
        |=> !q) else $error("reset term did not clear");
    ap_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !apsel
        |-> !ap) else $error("preset active while off");
    clk_src_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !clksel
        |-> clk_lvl == glob_clk) else $error("global clock not selected");
    ce_term_clk_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clksel
        |-> ce) else $error("enable gated a term clock");
    din_xor_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !dsel
        |-> din_a == xor_out) else $error("data not from xor");
    xor_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xorsel == cpmc_pkg::XOR_HIGH
        |-> xor_out == !or_sum) else $error("xor high level wrong");

    // output buffer enable sources
    oe_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        oesel == cpmc_pkg::OE_ON
        |=> pin_oe) else $error("enabled buffer off");
    oe_pin_b_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        oesel == cpmc_pkg::OE_PIN_B
        |=> pin_oe == !$past(output_enable_pin_b_n)) else $error("enable pin b not followed");
endmodule
`default_nettype wire

// ==== testbench/cpmc_ext_model.sv ====
// Purpose: far-side model of the pins that feed one macrocell
// Assumes: bench requests arrive as active-high levels sampled on core_clk
// Notes: pin levels change one core_clk edge after the request, as a real board would lag
`timescale 1ns/1ps
`default_nettype none
module cpmc_ext_model (
    input wire logic core_clk,
    input wire logic [cpmc_pkg::GSIG-1:0] sig_set,
    input wire logic clk_set,
    input wire logic clr_set,
    input wire logic oe_a_set,
    input wire logic oe_b_set,
    output logic [cpmc_pkg::GSIG-1:0] global_sig,
    output logic glob_clk,
    output logic global_clear_pin_n,
    output logic output_enable_pin_a_n,
    output logic output_enable_pin_b_n
);
    always_ff @(posedge core_clk)
    begin
        global_sig <= sig_set;
        glob_clk <= clk_set;
    end

    // asserted requests are driven low on the wire
    always_ff @(posedge core_clk)
    begin
        global_clear_pin_n <= ~clr_set;
        output_enable_pin_a_n <= ~oe_a_set;
        output_enable_pin_b_n <= ~oe_b_set;
    end
endmodule
`default_nettype wire

// ==== testbench/cpmc_top_bench.sv ====
// Purpose: self-checking bench for one macrocell
// Assumes: term0 = sig0, term1 = sig1, term2 = sig2 once the masks are written
// Notes: q is read back through the status word; regional and cascade inputs stay idle until the regional and cascade test
`timescale 1ns/1ps
`default_nettype none
module cpmc_top_bench;
    localparam logic [31:0] OR0 = 32'h0001_0000;
    logic core_clk;
    logic rst_n;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [33:0] sig_set;
    logic clk_set, clr_set, oea_set, oeb_set;
    logic [33:0] global_sig;
    logic glob_clk, clr_n, oea_n, oeb_n, pin_out, pin_oe, buried_fb, foldback_out;
    logic [31:0] v;
    logic [15:0] reg_in;
    logic casc_in;
    logic prev_q;
    logic e;
    int err_count;
    int num_checks;
    logic [2:0] mode_tab [0:8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3};
    logic [1:0] in_tab [0:8] = '{2'h1, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0};
    logic q_tab [0:8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [2:0] oe_tab [0:4] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6};

    cpmc_top i_cpmc_top (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .global_sig(global_sig), .regional_in(reg_in),
        .cascade_input(casc_in), .glob_clk(glob_clk), .global_clear_pin_n(clr_n),
        .output_enable_pin_a_n(oea_n), .output_enable_pin_b_n(oeb_n), .pin_out(pin_out),
        .pin_oe(pin_oe), .buried_fb(buried_fb), .foldback_out(foldback_out));

    cpmc_ext_model i_cpmc_ext_model (.core_clk(core_clk), .sig_set(sig_set), .clk_set(clk_set),
        .clr_set(clr_set), .oe_a_set(oea_set), .oe_b_set(oeb_set), .global_sig(global_sig),
        .glob_clk(glob_clk), .global_clear_pin_n(clr_n), .output_enable_pin_a_n(oea_n),
        .output_enable_pin_b_n(oeb_n));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask

    // covers the model lag, the edge detect and the output register
    task automatic settle;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic drive(input logic [2:0] s);
        @(posedge core_clk);
        sig_set <= {31'h0, s};
        settle();
    endtask

    task automatic set_clk(input logic c);
        @(posedge core_clk);
        clk_set <= c;
        settle();
    endtask

    task automatic pulse;
        set_clk(1'b1);
        set_clk(1'b0);
    endtask

    task automatic chk_q(input logic exp);
        rd_reg(cpmc_pkg::STAT_OFF, v);
        check("q", {31'h0, v[0]}, {31'h0, exp});
    endtask

    initial
    begin
        repeat (100000) @(posedge core_clk);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        err_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        sig_set = 34'h0;
        clk_set = 1'b0;
        clr_set = 1'b0;
        oea_set = 1'b0;
        oeb_set = 1'b0;
        reg_in = 16'h0000;
        casc_in = 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        wr_reg(cpmc_pkg::STAT_OFF, 32'hffff_ffff);
        rd_reg(cpmc_pkg::CFG_OFF, v);
        check("cfg reset", v, cpmc_pkg::CFG_RST);
        rd_reg(8'h50, v);
        check("unmapped read", v, 32'h0);
        check("oe after reset", {31'h0, pin_oe}, 32'h1);
        wr_reg(8'h10, 32'h1);
        wr_reg(8'h1c, 32'h2);
        wr_reg(8'h28, 32'h4);
        wr_reg(cpmc_pkg::ALLOC_OFF, 32'h1 << cpmc_pkg::AL_AUX);
        prev_q = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            wr_reg(cpmc_pkg::CFG_OFF, OR0 | ({29'h0, mode_tab[i]} << cpmc_pkg::CFG_MODE));
            drive({1'b0, in_tab[i]});
            chk_q(prev_q);
            pulse();
            chk_q(q_tab[i]);
            check("pin_out", {31'h0, pin_out}, {31'h0, q_tab[i]});
            check("buried_fb", {31'h0, buried_fb}, {31'h0, q_tab[i]});
            prev_q = q_tab[i];
        end
        // clock enable on term1 while the global clock runs
        wr_reg(cpmc_pkg::ALLOC_OFF, 32'h1 << cpmc_pkg::AL_CE);
        wr_reg(cpmc_pkg::CFG_OFF, OR0 | (32'h1 << cpmc_pkg::CFG_CE_EN));
        drive(3'h0);
        pulse();
        chk_q(1'b1);
        drive(3'h2);
        pulse();
        chk_q(1'b0);
        // term2 as the clock
        wr_reg(cpmc_pkg::ALLOC_OFF, 32'h2 << cpmc_pkg::AL_CLK);
        wr_reg(cpmc_pkg::CFG_OFF, OR0 | (32'h1 << cpmc_pkg::CFG_CLKSEL));
        drive(3'h1);
        pulse();
        chk_q(1'b0);
        drive(3'h5);
        chk_q(1'b1);
        // latch follows while the clock is high, holds while low
        wr_reg(cpmc_pkg::CFG_OFF, OR0 | (32'h6 << cpmc_pkg::CFG_MODE));
        set_clk(1'b1);
        drive(3'h0);
        chk_q(1'b0);
        drive(3'h1);
        chk_q(1'b1);
        set_clk(1'b0);
        drive(3'h0);
        chk_q(1'b1);
        // reset = clear pin or term2, preset = term1, no clock edges at all
        wr_reg(cpmc_pkg::ALLOC_OFF, (32'h2 << cpmc_pkg::AL_AR) | (32'h1 << cpmc_pkg::AL_AP));
        wr_reg(cpmc_pkg::CFG_OFF, OR0 | (32'h2 << cpmc_pkg::CFG_AR) | (32'h1 << cpmc_pkg::CFG_APSEL));
        drive(3'h4);
        chk_q(1'b0);
        drive(3'h2);
        chk_q(1'b1);
        @(posedge core_clk);
        clr_set <= 1'b1;
        settle();
        chk_q(1'b0);
        @(posedge core_clk);
        clr_set <= 1'b0;
        settle();
        chk_q(1'b1);
        drive(3'h0);
        // every enable source, with each pin asserted in turn
        wr_reg(cpmc_pkg::ALLOC_OFF, 32'h0);
        for (int p = 0; p < 2; p++)
        begin
            @(posedge core_clk);
            oea_set <= (p == 0);
            oeb_set <= (p == 1);
            drive({2'h0, p[0]});
            for (int k = 0; k < 5; k++)
            begin
                wr_reg(cpmc_pkg::CFG_OFF, {29'h0, oe_tab[k]} << cpmc_pkg::CFG_OE);
                settle();
                e = (k == 0) || (k == 2 && p == 0) || (k == 3 && p == 1) || (k == 4 && p == 1);
                check("pin_oe", {31'h0, pin_oe}, {31'h0, e});
            end
        end
        // combinatorial output and its feedback
        wr_reg(cpmc_pkg::CFG_OFF, OR0 | (32'h1 << cpmc_pkg::CFG_OSEL));
        drive(3'h0);
        check("comb out", {30'h0, pin_out, buried_fb}, 32'h0);
        drive(3'h1);
        check("comb out", {30'h0, pin_out, buried_fb}, 32'h3);
        wr_reg(cpmc_pkg::ALLOC_OFF, 32'h1 << cpmc_pkg::AL_DATA);
        wr_reg(cpmc_pkg::CFG_OFF, OR0 | 32'h0000_0601);
        pulse();
        chk_q(1'b0);
        check("fb of register", {30'h0, pin_out, buried_fb}, 32'h2);
        check("foldback", {31'h0, foldback_out}, 32'h0);
        drive(3'h0);
        check("foldback", {31'h0, foldback_out}, 32'h1);
        // regional literal joins term0, then cascade alone drives the sum
        wr_reg(8'h18, 32'h0000_0010);
        drive(3'h1);
        rd_reg(cpmc_pkg::STAT_OFF, v);
        check("term0 regional low", {31'h0, v[5]}, 32'h0);
        @(posedge core_clk);
        reg_in <= 16'h0001;
        settle();
        rd_reg(cpmc_pkg::STAT_OFF, v);
        check("term0 regional high", {31'h0, v[5]}, 32'h1);
        wr_reg(cpmc_pkg::CFG_OFF, 32'h1 << cpmc_pkg::CFG_OSEL);
        @(posedge core_clk);
        casc_in <= 1'b1;
        settle();
        check("cascade out", {31'h0, pin_out}, 32'h1);
        // clear pin alone as reset source
        wr_reg(cpmc_pkg::CFG_OFF, OR0 | (32'h1 << cpmc_pkg::CFG_AR));
        pulse();
        chk_q(1'b1);
        @(posedge core_clk);
        clr_set <= 1'b1;
        settle();
        chk_q(1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
